// ==== pll_clock_routing_control.v ====
// clock routing, divider and PLL configuration registers of the audio master clock generator
`include "clock_routing_defines.vh"

module pll_clock_routing_control (
	input  wire       clk,
	input  wire       reset,
	input  wire [6:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_write,
	input  wire       reg_read,
	output reg  [7:0] reg_rdata,
	output reg        reg_rvalid,
	input  wire       crystal_input_clock,
	input  wire       external_master_input,
	input  wire       first_pll_output,
	input  wire       pll_output_two,
	input  wire       pll_output_three,
	input  wire       pll_block_sysclk_512,
	input  wire       receiver_clock_512,
	input  wire       receiver_clock_256,
	input  wire       receiver_recovered_clock,
	output reg        master_clock_output,
	output reg        first_pll_reference,
	output reg        second_pll_reference,
	output reg        first_internal_pll_clock,
	output reg        second_internal_pll_clock,
	output reg        playback_conv_clock,
	output reg        record_conv_clock,
	output reg        first_internal_clock,
	output reg        second_internal_clock,
	output reg        first_system_clock,
	output reg        second_system_clock,
	output reg        third_system_clock,
	output reg  [1:0] first_pll_rate_sel,
	output reg  [1:0] second_pll_rate_sel,
	output reg        first_pll_ratio_sel,
	output reg        second_pll_ratio_sel,
	output reg        first_pll_rate_double,
	output reg        second_pll_rate_double,
	output reg        first_pll_powerdown,
	output reg        second_pll_powerdown,
	output reg        crystal_osc_powerdown
);

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	// one byte per mapped offset; reserved bits are dropped on write
	reg  [7:0] pll_divider_powerdown;
	reg  [7:0] pll_rate_config;
	reg  [7:0] converter_clock_select;
	reg  [7:0] internal_clock_select;
	reg  [7:0] pll_reference_select;
	reg  [7:0] output_enable;

	// ----------------------------------------------------------------
	// decoded fields
	// ----------------------------------------------------------------
	wire [1:0] recovered_clock_route;
	wire       master_out_halve;
	wire       pll_reference_halve;
	wire       third_system_clock_half_rate;
	wire [2:0] playback_conv_clock_sel;
	wire [2:0] record_conv_clock_sel;
	wire [1:0] first_internal_clock_sel;
	wire [1:0] second_internal_clock_sel;
	wire       first_pll_output_sel;
	wire [1:0] second_pll_output_sel;
	wire       first_pll_ref_sel;
	wire       second_pll_ref_sel;

	// slices of the register bytes, named by the path they steer
	assign recovered_clock_route     = pll_divider_powerdown[`POS_RECOVERED_ROUTE +: 2];
	assign master_out_halve          = pll_divider_powerdown[`POS_MASTER_OUT_HALVE];
	assign pll_reference_halve       = pll_divider_powerdown[`POS_REF_HALVE];
	assign third_system_clock_half_rate         = pll_divider_powerdown[`POS_THIRD_SYSTEM_CLOCK_HALF];
	assign playback_conv_clock_sel   = converter_clock_select[`POS_PLAYBACK_SEL +: 3];
	assign record_conv_clock_sel     = converter_clock_select[`POS_RECORD_SEL +: 3];
	assign second_internal_clock_sel = converter_clock_select[`POS_SECOND_ICLK_SEL +: 2];
	assign first_internal_clock_sel  = internal_clock_select[`POS_FIRST_ICLK_SEL +: 2];
	assign second_pll_output_sel     = internal_clock_select[`POS_SECOND_PLL_OSEL +: 2];
	assign first_pll_output_sel      = internal_clock_select[`POS_FIRST_PLL_OSEL];
	assign first_pll_ref_sel         = pll_reference_select[`POS_FIRST_PLL_REF];
	assign second_pll_ref_sel        = pll_reference_select[`POS_SECOND_PLL_REF];

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// reserved bits are masked on write so they always read back as zero
	always @(posedge clk) begin
		if (reset) begin
			pll_divider_powerdown  <= `RST_PLL_DIVIDER_POWERDOWN;
			pll_rate_config        <= `RST_PLL_RATE_CONFIG;
			converter_clock_select <= `RST_CONVERTER_CLOCK_SEL;
			internal_clock_select  <= `RST_INTERNAL_CLOCK_SEL;
			pll_reference_select   <= `RST_PLL_REFERENCE_SEL;
			output_enable          <= `RST_OUTPUT_ENABLE;
		end else if (reg_write) begin
			case (reg_addr)
				`ADDR_PLL_DIVIDER_POWERDOWN: pll_divider_powerdown <= reg_wdata;
				`ADDR_PLL_RATE_CONFIG:       pll_rate_config <= reg_wdata;
				`ADDR_CONVERTER_CLOCK_SEL:   converter_clock_select <= reg_wdata;
				`ADDR_INTERNAL_CLOCK_SEL:    internal_clock_select <= reg_wdata & `MASK_INTERNAL_CLOCK_SEL;
				`ADDR_PLL_REFERENCE_SEL:     pll_reference_select <= reg_wdata & `MASK_PLL_REFERENCE_SEL;
				`ADDR_OUTPUT_ENABLE:         output_enable <= reg_wdata & `MASK_OUTPUT_ENABLE;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	// unmapped offsets answer zero so software never sees stale data
	always @(posedge clk) begin
		if (reset) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_read;
			if (reg_read) begin
				case (reg_addr)
					`ADDR_PLL_DIVIDER_POWERDOWN: reg_rdata <= pll_divider_powerdown;
					`ADDR_PLL_RATE_CONFIG:       reg_rdata <= pll_rate_config;
					`ADDR_CONVERTER_CLOCK_SEL:   reg_rdata <= converter_clock_select;
					`ADDR_INTERNAL_CLOCK_SEL:    reg_rdata <= internal_clock_select;
					`ADDR_PLL_REFERENCE_SEL:     reg_rdata <= pll_reference_select;
					`ADDR_OUTPUT_ENABLE:         reg_rdata <= output_enable;
					default:                     reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// source gating for powered-down units
	// ----------------------------------------------------------------
	// a stopped unit holds its clock low and its halved copy freezes at its last level, so no stale edge passes
	wire crystal_live;
	wire first_pll_live;
	wire second_fs2_live;
	wire second_fs3_live;

	assign crystal_live    = crystal_input_clock & ~pll_divider_powerdown[`POS_CRYSTAL_PD];
	assign first_pll_live  = first_pll_output & ~pll_divider_powerdown[`POS_FIRST_PLL_PD];
	assign second_fs2_live = pll_output_two & ~pll_divider_powerdown[`POS_SECOND_PLL_PD];
	assign second_fs3_live = pll_output_three & ~pll_divider_powerdown[`POS_SECOND_PLL_PD];

	// ----------------------------------------------------------------
	// divide-by-two stages
	// ----------------------------------------------------------------
	// index 0 external, 1 crystal, 2 first PLL, 3 output two, 4 output three, 5 sysclk source
	wire [`NUM_HALVERS-1:0] halver_in;
	wire [`NUM_HALVERS-1:0] halved;

	assign halver_in = {pll_block_sysclk_512, second_fs3_live, second_fs2_live,
		first_pll_live, crystal_live, external_master_input};

	// each stage toggles on a rising edge; inputs must stay below a quarter of clk
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_HALVERS; gi = gi + 1) begin : g_halve
			// stage state stays local so every flop has a single driver
			reg prev_level;  // last sample of the source
			reg half_level;  // divided clock of this stage

			always @(posedge clk) begin
				if (reset) begin
					prev_level <= 1'b0;
					half_level <= 1'b0;
				end else begin
					prev_level <= halver_in[gi];
					if (halver_in[gi] & ~prev_level) begin
						half_level <= ~half_level;
					end
				end
			end

			assign halved[gi] = half_level;
		end
	endgenerate

	// ----------------------------------------------------------------
	// clock selection network
	// ----------------------------------------------------------------
	// one next value per registered clock output except the first and second system clocks, plus the PLL master clock
	reg next_master_out;
	reg next_pll_master;
	reg next_first_ref;
	reg next_second_ref;
	reg next_first_int_pll;
	reg next_second_int_pll;
	reg next_playback;
	reg next_record;
	reg next_first_iclk;
	reg next_second_iclk;
	reg next_third_sys;

	// master output and the PLL master clock derived from the crystal
	always @* begin
		next_master_out = master_out_halve ? halved[0] : external_master_input;
		next_pll_master = pll_reference_halve ? halved[1] : crystal_live;
	end

	// PLL references: the external input is never divided on this path
	always @* begin
		next_first_ref  = first_pll_ref_sel ? external_master_input : next_pll_master;
		next_second_ref = second_pll_ref_sel ? external_master_input : next_pll_master;
	end

	// internal PLL clocks, full or halved
	always @* begin
		next_first_int_pll = first_pll_output_sel ? halved[2] : first_pll_live;
		case (second_pll_output_sel)
			2'h0:    next_second_int_pll = second_fs2_live;
			2'h1:    next_second_int_pll = halved[3];
			2'h2:    next_second_int_pll = second_fs3_live;
			2'h3:    next_second_int_pll = halved[4];
			default: next_second_int_pll = second_fs2_live;
		endcase
	end

	// converter clocks share one encoding; spare codes fall back to the crystal
	always @* begin
		case (playback_conv_clock_sel)
			3'h0:    next_playback = crystal_live;
			3'h1:    next_playback = external_master_input;
			3'h2:    next_playback = next_first_int_pll;
			3'h3:    next_playback = next_second_int_pll;
			3'h4:    next_playback = receiver_clock_512;
			3'h5:    next_playback = receiver_clock_256;
			default: next_playback = crystal_live;
		endcase
	end

	// record converter clock, same encoding as playback
	always @* begin
		case (record_conv_clock_sel)
			3'h0:    next_record = crystal_live;
			3'h1:    next_record = external_master_input;
			3'h2:    next_record = next_first_int_pll;
			3'h3:    next_record = next_second_int_pll;
			3'h4:    next_record = receiver_clock_512;
			3'h5:    next_record = receiver_clock_256;
			default: next_record = crystal_live;
		endcase
	end

	// the two internal clocks
	always @* begin
		case (first_internal_clock_sel)
			2'h0:    next_first_iclk = crystal_live;
			2'h1:    next_first_iclk = external_master_input;
			2'h2:    next_first_iclk = next_first_int_pll;
			2'h3:    next_first_iclk = next_second_int_pll;
			default: next_first_iclk = crystal_live;
		endcase
	end

	// second internal clock, same four sources as the first
	always @* begin
		case (second_internal_clock_sel)
			2'h0:    next_second_iclk = crystal_live;
			2'h1:    next_second_iclk = external_master_input;
			2'h2:    next_second_iclk = next_first_int_pll;
			2'h3:    next_second_iclk = next_second_int_pll;
			default: next_second_iclk = crystal_live;
		endcase
	end

	// third system clock: reserved route codes keep the PLL block source
	always @* begin
		if (recovered_clock_route == `ROUTE_RECEIVER) begin
			next_third_sys = receiver_recovered_clock;
		end else begin
			next_third_sys = third_system_clock_half_rate ? halved[5] : pll_block_sysclk_512;
		end
	end

	// ----------------------------------------------------------------
	// output flops
	// ----------------------------------------------------------------
	// registering every clock adds one cycle of latency but keeps outputs glitch free
	always @(posedge clk) begin
		if (reset) begin
			master_clock_output       <= 1'b0;
			first_pll_reference       <= 1'b0;
			second_pll_reference      <= 1'b0;
			first_internal_pll_clock  <= 1'b0;
			second_internal_pll_clock <= 1'b0;
			playback_conv_clock       <= 1'b0;
			record_conv_clock         <= 1'b0;
			first_internal_clock      <= 1'b0;
			second_internal_clock     <= 1'b0;
			first_system_clock        <= 1'b0;
			second_system_clock       <= 1'b0;
			third_system_clock        <= 1'b0;
		end else begin
			master_clock_output       <= next_master_out;
			first_pll_reference       <= next_first_ref;
			second_pll_reference      <= next_second_ref;
			first_internal_pll_clock  <= next_first_int_pll;
			second_internal_pll_clock <= next_second_int_pll;
			playback_conv_clock       <= next_playback;
			record_conv_clock         <= next_record;
			first_internal_clock      <= next_first_iclk;
			second_internal_clock     <= next_second_iclk;
			first_system_clock        <= first_pll_live & ~output_enable[`POS_SYS1_DISABLE];
			second_system_clock       <= second_fs2_live & ~output_enable[`POS_SYS2_DISABLE];
			third_system_clock        <= next_third_sys & ~output_enable[`POS_SYS3_DISABLE];
		end
	end

	// ----------------------------------------------------------------
	// analog PLL configuration outputs
	// ----------------------------------------------------------------
	// rate codes pass unchanged; the reserved code is the analog side's concern
	always @(posedge clk) begin
		if (reset) begin
			first_pll_rate_sel     <= 2'h0;
			second_pll_rate_sel    <= 2'h0;
			first_pll_ratio_sel    <= 1'b0;
			second_pll_ratio_sel   <= 1'b0;
			first_pll_rate_double  <= 1'b0;
			second_pll_rate_double <= 1'b0;
			first_pll_powerdown    <= 1'b0;
			second_pll_powerdown   <= 1'b0;
			crystal_osc_powerdown  <= 1'b0;
		end else begin
			second_pll_rate_sel    <= pll_rate_config[`POS_SECOND_RATE +: 2];
			first_pll_rate_sel     <= pll_rate_config[`POS_FIRST_RATE +: 2];
			second_pll_ratio_sel   <= pll_rate_config[`POS_SECOND_RATIO];
			first_pll_ratio_sel    <= pll_rate_config[`POS_FIRST_RATIO];
			second_pll_rate_double <= pll_rate_config[`POS_SECOND_DOUBLE];
			first_pll_rate_double  <= pll_rate_config[`POS_FIRST_DOUBLE];
			second_pll_powerdown   <= pll_divider_powerdown[`POS_SECOND_PLL_PD];
			first_pll_powerdown    <= pll_divider_powerdown[`POS_FIRST_PLL_PD];
			crystal_osc_powerdown  <= pll_divider_powerdown[`POS_CRYSTAL_PD];
		end
	end

endmodule // pll_clock_routing_control

// ==== clock_routing_defines.vh ====
// register map, field positions and reset values of the clock routing control
`ifndef CLOCK_ROUTING_DEFINES_VH
`define CLOCK_ROUTING_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_PLL_DIVIDER_POWERDOWN 7'h74
`define ADDR_PLL_RATE_CONFIG       7'h75
`define ADDR_CONVERTER_CLOCK_SEL   7'h76
`define ADDR_INTERNAL_CLOCK_SEL    7'h77
`define ADDR_PLL_REFERENCE_SEL     7'h78
`define ADDR_OUTPUT_ENABLE         7'h7A

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PLL_DIVIDER_POWERDOWN 8'h00
`define RST_PLL_RATE_CONFIG       8'h00
`define RST_CONVERTER_CLOCK_SEL   8'h00
`define RST_INTERNAL_CLOCK_SEL    8'h00
`define RST_PLL_REFERENCE_SEL     8'h00
`define RST_OUTPUT_ENABLE         8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define POS_RECOVERED_ROUTE   6
`define POS_MASTER_OUT_HALVE  5
`define POS_REF_HALVE         4
`define POS_SECOND_PLL_PD     3
`define POS_FIRST_PLL_PD      2
`define POS_CRYSTAL_PD        1
`define POS_THIRD_SYSTEM_CLOCK_HALF      0
`define POS_SECOND_RATE       6
`define POS_SECOND_RATIO      5
`define POS_SECOND_DOUBLE     4
`define POS_FIRST_RATE        2
`define POS_FIRST_RATIO       1
`define POS_FIRST_DOUBLE      0
`define POS_PLAYBACK_SEL      5
`define POS_RECORD_SEL        2
`define POS_SECOND_ICLK_SEL   0
`define POS_FIRST_ICLK_SEL    3
`define POS_SECOND_PLL_OSEL   1
`define POS_FIRST_PLL_OSEL    0
`define POS_SECOND_PLL_REF    7
`define POS_FIRST_PLL_REF     6
`define POS_SYS1_DISABLE      2
`define POS_SYS2_DISABLE      1
`define POS_SYS3_DISABLE      0

// ----------------------------------------------------------------
// writable masks and codes
// ----------------------------------------------------------------
`define MASK_INTERNAL_CLOCK_SEL 8'h1F
`define MASK_PLL_REFERENCE_SEL  8'hC0
`define MASK_OUTPUT_ENABLE      8'h07
`define ROUTE_RECEIVER          2'h3
`define NUM_HALVERS             6

`endif

// ==== clock_source_model.sv ====
// free-running level sources standing in for crystal, plls and receiver
module clock_source_model (
	input  wire logic       clk,
	input  wire logic       reset,
	output logic      [8:0] levels
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] count = 16'h0000;

	// advance just after the edge, same skew as the bench drivers
	always @(posedge clk) begin
		count <= #1 reset ? 16'h0000 : count + 16'h0001;
	end

	// source i toggles every 3+i cycles: distinct rates, all slower than clk/4
	always_comb begin
		for (int i = 0; i < 9; i++)
			levels[i] = ((count / (i + 3)) % 2) == 1;
	end
endmodule // clock_source_model

// ==== routing_checker.sv ====
// concurrent checks on the ports of the clock routing control
`include "clock_routing_defines.vh"
module routing_checker (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       crystal_input_clock,
	input wire logic       external_master_input,
	input wire logic       receiver_recovered_clock,
	input wire logic       master_clock_output,
	input wire logic       first_pll_reference,
	input wire logic       second_pll_reference,
	input wire logic       first_system_clock,
	input wire logic       second_system_clock,
	input wire logic       third_system_clock,
	input wire logic [1:0] first_pll_rate_sel,
	input wire logic [1:0] second_pll_rate_sel,
	input wire logic       first_pll_ratio_sel,
	input wire logic       second_pll_ratio_sel,
	input wire logic       first_pll_rate_double,
	input wire logic       second_pll_rate_double,
	input wire logic       first_pll_powerdown,
	input wire logic       second_pll_powerdown,
	input wire logic       crystal_osc_powerdown
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// -------------------------------------------------
	// shadow of the steering registers
	// -------------------------------------------------
	logic [7:0] sh_pd;
	logic [7:6] sh_ref;
	logic [2:0] sh_oe;
	wire  [2:0] wd_pd     = reg_wdata[3:1];
	wire        halve_off = !sh_pd[5];
	wire        rec_route = sh_pd[7:6] == 2'b11 && sh_pd[3:1] == 3'b000 && !sh_oe[0];
	wire        ref1_ext  = sh_ref[6];
	wire        ref1_xtal = !sh_ref[6] && !sh_pd[4] && !sh_pd[1];
	wire        oe3_off   = sh_oe[0];
	wire        oe1_off   = sh_oe[2];

	// shadows follow the same write edge as the design registers
	always_ff @(posedge clk) begin
		if (reset) begin
			sh_pd  <= 8'h00;
			sh_ref <= 2'h0;
			sh_oe  <= 3'h0;
		end else if (reg_write) begin
			if (reg_addr == `ADDR_PLL_DIVIDER_POWERDOWN) sh_pd <= reg_wdata;
			if (reg_addr == `ADDR_PLL_REFERENCE_SEL) sh_ref <= reg_wdata[7:6];
			if (reg_addr == `ADDR_OUTPUT_ENABLE) sh_oe <= reg_wdata[2:0];
		end
	end

	sequence s_rate_write;
		reg_write && reg_addr == `ADDR_PLL_RATE_CONFIG;
	endsequence
	sequence s_pd_write;
		reg_write && reg_addr == `ADDR_PLL_DIVIDER_POWERDOWN;
	endsequence

	// -------------------------------------------------
	// assertions
	// -------------------------------------------------
	a_read_answer: assert property (reg_read |=> reg_rvalid) else $error("read not answered in one cycle");
	a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_read)) else $error("read valid without request");
	a_unmapped_zero: assert property (reg_read && !(reg_addr inside {[7'h74:7'h78], 7'h7A}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rate_fields: assert property (s_rate_write |=> ##1 {second_pll_rate_sel, second_pll_ratio_sel,
		second_pll_rate_double, first_pll_rate_sel, first_pll_ratio_sel, first_pll_rate_double} == $past(reg_wdata, 2))
		else $error("rate configuration outputs wrong");
	a_pd_fields: assert property (s_pd_write |=> ##1 {second_pll_powerdown, first_pll_powerdown,
		crystal_osc_powerdown} == $past(wd_pd, 2)) else $error("power-down outputs wrong");
	a_master_direct: assert property (!$past(reset) && halve_off && $past(halve_off) |->
		master_clock_output == $past(external_master_input)) else $error("master output not direct");
	a_third_recovered: assert property (!$past(reset) && $past(rec_route) |->
		third_system_clock == $past(receiver_recovered_clock)) else $error("third clock not recovered clock");
	a_third_disabled: assert property ($past(oe3_off) |-> !third_system_clock) else $error("third clock not held off");
	a_first_disabled: assert property ($past(oe1_off) |-> !first_system_clock) else $error("first clock not held off");
	a_ref_external: assert property (!$past(reset) && $past(ref1_ext) |->
		first_pll_reference == $past(external_master_input)) else $error("first reference not external");
	a_ref_crystal: assert property (!$past(reset) && $past(ref1_xtal) |->
		first_pll_reference == $past(crystal_input_clock)) else $error("first reference not crystal");
	a_ref2_external: assert property (!$past(reset) && $past(sh_ref[7]) |->
		second_pll_reference == $past(external_master_input)) else $error("second reference not external");
	a_second_disabled: assert property ($past(sh_oe[1]) |-> !second_system_clock)
		else $error("second clock not held off");
endmodule // routing_checker

// ==== tb_top.sv ====
// self-checking bench for the clock routing control
`include "clock_routing_defines.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk       = 1'b0;
	logic        reset     = 1'b1;
	logic [6:0]  reg_addr  = 7'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_write = 1'b0;
	logic        reg_read  = 1'b0;
	wire  [7:0]  reg_rdata;
	wire         reg_rvalid;
	wire  [8:0]  src;
	wire  [8:0]  probe;
	int          miscompares = 0;
	int          checks      = 0;
	int          mism, ro, ri;
	logic        ok;
	logic [6:0]  regs [6] = '{7'h74, 7'h75, 7'h76, 7'h77, 7'h78, 7'h7A};
	// rows: offset, data, probed output, source, mode (0 direct, 1 halved, 2 silent, 3 none)
	logic [27:0] rows [$] = {28'h7600400, 28'h7624410, 28'h7624510, 28'h7648003, 28'h766C003,
		28'h7690460, 28'h76B4570, 28'h76D8400, 28'h76FC500, 28'h7601710, 28'h7602003, 28'h7603003,
		28'h7600700, 28'h7708610, 28'h7710003, 28'h7718003, 28'h7700600, 28'h7701321, 28'h7700320,
		28'h7702831, 28'h7704840, 28'h7706841, 28'h7700003, 28'h7420111, 28'h7400110, 28'h7410201,
		28'h7840210, 28'h7800201, 28'h7880003, 28'h7800003, 28'h7401051, 28'h7400050, 28'h74C0080,
		28'h7440050, 28'h7A01052, 28'h7A00003, 28'h7402402, 28'h7408802, 28'h7404302, 28'h7400003,
		28'h75A5003, 28'h755A003, 28'h7500003};

	always #2.5 clk = ~clk;

	pll_clock_routing_control pll_clock_routing_control_i (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .crystal_input_clock(src[0]), .external_master_input(src[1]),
		.first_pll_output(src[2]), .pll_output_two(src[3]), .pll_output_three(src[4]),
		.pll_block_sysclk_512(src[5]), .receiver_clock_512(src[6]), .receiver_clock_256(src[7]),
		.receiver_recovered_clock(src[8]), .third_system_clock(probe[0]), .master_clock_output(probe[1]),
		.first_pll_reference(probe[2]), .first_internal_pll_clock(probe[3]), .playback_conv_clock(probe[4]),
		.record_conv_clock(probe[5]), .first_internal_clock(probe[6]), .second_internal_clock(probe[7]),
		.second_internal_pll_clock(probe[8]), .second_pll_reference(), .first_system_clock(),
		.second_system_clock(), .first_pll_rate_sel(), .second_pll_rate_sel(), .first_pll_ratio_sel(),
		.second_pll_ratio_sel(), .first_pll_rate_double(), .second_pll_rate_double(),
		.first_pll_powerdown(), .second_pll_powerdown(), .crystal_osc_powerdown());

	clock_source_model clock_source_model_i (.clk(clk), .reset(reset), .levels(src));

	// -------------------------------------------------
	// tasks
	// -------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// optional write, then a read in the very next cycle
	task automatic wrc(input logic [6:0] a, input logic [7:0] d, input logic [7:0] e, input logic w);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_write = w;
		@(posedge clk);
		#1;
		reg_write = 1'b0;
		reg_read = 1'b1;
		@(posedge clk);
		#1;
		reg_read = 1'b0;
		check({7'h00, reg_rvalid}, 8'h01);
		check(reg_rdata, e);
	endtask

	// sample away from the edge: output vs last input, rising edges of both
	task automatic watch(input logic [3:0] o, input logic [3:0] i);
		logic last_o;
		logic last_i;
		mism = 0;
		ro = 0;
		ri = 0;
		@(posedge clk);
		#2;
		last_o = probe[o];
		last_i = src[i];
		repeat (80) begin
			@(posedge clk);
			#2;
			if (probe[o] !== last_i) mism++;
			if (probe[o] && !last_o) ro++;
			if (src[i] && !last_i) ri++;
			last_o = probe[o];
			last_i = src[i];
		end
	endtask

	task automatic results();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// -------------------------------------------------
	// main sequence
	// -------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		#1;
		reset = 1'b0;
		foreach (rows[k]) begin
			wrc(rows[k][26:20], rows[k][19:12], rows[k][19:12], 1'b1);
			if (rows[k][3:0] != 4'h3) begin
				repeat (4) @(posedge clk);
				watch(rows[k][11:8], rows[k][7:4]);
				case (rows[k][3:0])
					4'h0: ok = (mism == 0);
					4'h1: ok = (2 * ro >= ri - 2) && (2 * ro <= ri + 2);
					default: ok = (ro == 0);
				endcase
				check({7'h00, ok}, 8'h01);
			end
		end
		// reserved bits and unmapped offsets read as zero
		wrc(7'h77, 8'hFF, 8'h1F, 1'b1);
		wrc(7'h78, 8'hFF, 8'hC0, 1'b1);
		wrc(7'h7A, 8'hFF, 8'h07, 1'b1);
		wrc(7'h79, 8'h5A, 8'h00, 1'b1);
		wrc(7'h73, 8'h5A, 8'h00, 1'b1);
		wrc(7'h74, 8'hFF, 8'hFF, 1'b1);
		// reset in mid-run must clear every register
		@(posedge clk);
		#1;
		reset = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		reset = 1'b0;
		foreach (regs[k]) wrc(regs[k], 8'h00, 8'h00, 1'b0);
		results();
	end

	// watchdog: a hang counts as a mismatch
	initial begin
		#100000;
		miscompares++;
		results();
	end
endmodule // tb_top

bind pll_clock_routing_control routing_checker routing_checker_i (.*);
